// *** tb/ebrp_port_sva.sv ***
// assertions on the port bus and the core reset lines
`timescale 1ns/1ps
module ebrp_port_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [1:0]  addr,
  input wire logic        write,
  input wire logic        read,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        core_reset_req,
  input wire logic        core_reset_ack
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] sync_q;
  logic       edge_q;
  logic       cleared_q;
  wire        clr = write && addr == 2'h3;
  ////////////////////////////////////////////////////////////////
  // reference copy of the synchroniser and the capture bit
  always_ff @(posedge aclk) begin
    if (!aresetn) sync_q <= 3'h0;
    else sync_q <= {sync_q[1:0], core_reset_ack};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) edge_q <= 1'b0;
    else edge_q <= (sync_q[1] && !sync_q[2]) || (edge_q && !clr);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) cleared_q <= 1'b0;
    else if (clr) cleared_q <= 1'b1;
    else if (write && addr == 2'h0 && wdata[0]) cleared_q <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  a_req_follows_write: assert property (write && addr == 2'h0 |=> core_reset_req == $past(wdata[0]))
    else $error("reset request does not follow the data write");
  a_req_holds: assert property (!(write && addr == 2'h0) |=> $stable(core_reset_req))
    else $error("reset request moved without a data write");
  a_read_answers: assert property (read |=> rvalid)
    else $error("read not answered one cycle later");
  a_rvalid_cause: assert property (rvalid |-> $past(read))
    else $error("read answer without a read");
  a_edge_readback: assert property (read && addr == 2'h3 |=> rdata == {31'h0, $past(edge_q)})
    else $error("capture bit read back wrong");
  a_upper_bits_zero: assert property (rvalid |-> rdata[31:1] == 31'h0)
    else $error("port read shows more than one bit");
  a_clear_first: assert property (write && addr == 2'h0 && wdata[0] |-> cleared_q)
    else $error("reset requested without clearing capture first");
  a_pulse_caught: assert property ($rose(core_reset_ack) ##[3:5] (read && addr == 2'h3) |=> rdata[0])
    else $error("acknowledge pulse not captured");
  c_clear_then_req: cover property (clr ##[1:20] (write && addr == 2'h0 && wdata[0]));
  c_edge_seen: cover property (read && addr == 2'h3 ##1 rdata[0]);
  c_release: cover property ($fell(core_reset_req));
endmodule : ebrp_port_sva

// *** tb/tb_external_boot_reset_port.sv ***
// self-checking bench for the boot host and reset port pair
`timescale 1ns/1ps
module tb_external_boot_reset_port;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic [1:0]  resp;
  } ebrp_exp_s;
  logic        aclk = 1'b0, aresetn = 1'b0, stale = 1'b0, core_reset_ack = 1'b0, mem_ready = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, mem_valid;
  logic        core_reset_req;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, mem_addr, mem_wdata, ra, ca, cd, d;
  logic [31:0] bad [3] = '{32'h0000_8000, 32'h0000_0006, 32'hFFFF_7FFC};
  logic [31:0] good [3] = '{32'hFFFF_8000, 32'h0000_7FFC, 32'h0000_0010};
  int          miscompares = 0, tests_run = 0, n_ack = 0, n0;
  ebrp_exp_s   e;
  ebrp_exp_s   exp_q[$];
  logic [63:0] mem_q[$];
  always #50 aclk = ~aclk;
  ebrp_bus_if bus_if ();
  ebrp_port ebrp_port_i (.aclk, .aresetn, .bus(bus_if.port_end), .core_reset_req, .core_reset_ack);
  ebrp_host ebrp_host_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
    .bus(bus_if.host_end), .mem_addr, .mem_wdata, .mem_valid, .mem_ready);
  ebrp_port_sva ebrp_port_sva_i (.aclk, .aresetn, .addr(bus_if.addr), .write(bus_if.write),
    .read(bus_if.read), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid),
    .core_reset_req, .core_reset_ack);
  ////////////////////////////////////////////////////////////////
  // core side: drains for a while, then pulses the acknowledge
  always @(posedge aclk) begin
    if ((core_reset_req || stale) && !core_reset_ack && $urandom_range(7) == 0) begin
      core_reset_ack <= 1'b1;
      n_ack <= n_ack + int'(core_reset_req);
    end else begin
      core_reset_ack <= 1'b0;
    end
    mem_ready <= 1'($urandom_range(1));
  end
  task automatic check(input logic [65:0] seen, input logic [65:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check
  always @(posedge aclk) begin
    if (aresetn && ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))) begin
      e = exp_q.pop_front();
      check({s_axi_rvalid ? s_axi_rdata & e.mask : 32'h0000_0000, s_axi_rvalid ? s_axi_rresp : s_axi_bresp},
            {e.data & e.mask, e.resp});
    end
    if (aresetn && mem_valid && mem_ready) check({mem_addr, mem_wdata}, mem_q.pop_front());
  end
  ////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    exp_q.push_back('{32'h0000_0000, 32'h0000_0000, r});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] dt, input logic [31:0] m, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    exp_q.push_back('{dt, m, r});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  // wait for one event, then mask it, read it and clear it
  task automatic wait_irq(input logic [2:0] b);
    wr(8'h1C, {29'h0, b});
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge aclk);
    check(irq, 1'b1);
    wr(8'h1C, 32'h0000_0000);
    check(irq, 1'b0);
    rd(8'h18, {29'h0, b}, {29'h0, b});
    wr(8'h18, {29'h0, b});
    rd(8'h18, 32'h0000_0000, 32'h0000_0007);
  endtask : wait_irq
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////
  initial begin
    #2_000_000;
    miscompares++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h1149_cf02));
    good[2] = $urandom & 32'h0000_3FFC;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(core_reset_req, 1'b0);
    rd(8'h04, 32'h0000_0000, 32'h0000_00FF);
    rd(8'h18, 32'h0000_0000, 32'h0000_0007);
    rd(8'h24, 32'h0000_0000, 32'hFFFF_FFFF, 2'h2);
    wr(8'h02, 32'h0000_0001, 2'h2);
    // release and copy outside the loaded state only raise the error event
    wr(8'h00, 32'h0000_0002);
    wr(8'h14, 32'h0000_00A5);
    wait_irq(3'h4);
    check(core_reset_req, 1'b0);
    $display("reset and map test done");
    // a stale acknowledge edge before any boot
    stale <= 1'b1;
    repeat (30) @(posedge aclk);
    stale <= 1'b0;
    repeat (20) @(posedge aclk);
    for (int k = 0; k < 3; k++) begin
      ra = $urandom & 32'h00FF_FFFC;
      n0 = n_ack;
      wr(8'h08, ra);
      wr(8'h00, 32'h0000_0001);
      wait_irq(3'h1);
      check(n_ack > n0, 1'b1);
      check(core_reset_req, 1'b1);
      rd(8'h04, 32'h0000_0035, 32'h0000_003F);
      ca = $urandom & 32'hFFFF_FFFC;
      cd = $urandom;
      wr(8'h10, ca);
      mem_q.push_back({ca, cd});
      wr(8'h14, cd);
      wr(8'h0C, ra + 32'h0000_0004 + bad[k]);
      wr(8'h00, 32'h0000_0002);
      wait_irq(3'h4);
      rd(8'h04, 32'h0000_00B5, 32'h0000_00BF);
      d = good[k];
      mem_q.push_back({ra, 10'h000, d[15:0], 6'h06});
      wr(8'h0C, ra + 32'h0000_0004 + d);
      wr(8'h00, 32'h0000_0002);
      wait_irq(3'h2);
      check(core_reset_req, 1'b0);
      rd(8'h20, {10'h000, d[15:0], 6'h06}, 32'hFFFF_FFFF);
      $display("boot %0d done", k);
    end
    complete_run();
  end
endmodule : tb_external_boot_reset_port

// *** verilog/ebrp_bus_if.sv ***
// word-addressed register bus between the boot host and the reset port
`timescale 1ns/1ps
interface ebrp_bus_if;
  logic [1:0]  addr;
  logic        write;
  logic        read;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        rvalid;

  modport port_end (
    input  addr,
    input  write,
    input  read,
    input  wdata,
    output rdata,
    output rvalid
  );

  modport host_end (
    output addr,
    output write,
    output read,
    output wdata,
    input  rdata,
    input  rvalid
  );
endinterface : ebrp_bus_if

// *** verilog/ebrp_host.sv ***
// boot host: drives the reset port through the boot sequence under AXI4-Lite control
// Behaviour
// - writing one raises reset request, zero lowers
// - acknowledge level readable through the data offset
// - acknowledge pulse captured in hardware
// - one bit, synchronous rising-edge capture only
// - rising edge sets capture bit until cleared
// - capture bit readable any time
// - clear capture by writing offset three first
// - then write one to offset zero
// - poll offset three until one, then load
// - image held locally, sections copied, entry kept
// - displacement is entry minus reset minus four
// - displacement must fit sixteen signed bits
// - branch word zeros, displacement, opcode six
// - store branch, then write zero to offset zero
// - core finishes pipeline before entering reset
// - acknowledge repeats while request stays high
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ebrp_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output wire logic        irq,
  ebrp_bus_if.host_end     bus,
  output wire logic [31:0] mem_addr,
  output wire logic [31:0] mem_wdata,
  output wire logic        mem_valid,
  input  wire logic        mem_ready
);

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_CLEAR   = 4'b0001,
    ST_REQ     = 4'b0010,
    ST_POLL    = 4'b0011,
    ST_WAIT    = 4'b0100,
    ST_LOADED  = 4'b0101,
    ST_COPY    = 4'b0110,
    ST_BRANCH  = 4'b0111,
    ST_RELEASE = 4'b1000
  } ebrp_state_e;

  ebrp_state_e state_q;
  logic [7:0]  awaddr_q;
  logic        aw_have_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_have_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        rvalid_q;
  logic [31:0] reset_addr_q;
  logic [31:0] entry_q;
  logic [31:0] copy_addr_q;
  logic [31:0] copy_data_q;
  logic [31:0] mem_addr_q;
  logic [31:0] mem_wdata_q;
  logic [2:0]  irq_st_q;
  logic [2:0]  irq_mask_q;
  logic        done_q;
  logic        wr_fire;
  logic        wr_map;
  logic        start_cmd;
  logic        release_cmd;
  logic        copy_cmd;
  logic [31:0] disp;
  logic        disp_ok;
  logic [2:0]  ev;

  assign disp    = ebrp_pkg::ebrp_disp(reset_addr_q, entry_q);
  assign disp_ok = ebrp_pkg::ebrp_disp_ok(disp);

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data in either order
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign wr_fire       = aw_have_q && w_have_q && !bvalid_q && state_q != ST_COPY;
  assign wr_map        = awaddr_q <= ebrp_pkg::HOST_BRWORD_OFS && awaddr_q[1:0] == 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= ebrp_pkg::WORD_RST_VAL;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= ebrp_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_map ? ebrp_pkg::AXI_OKAY : ebrp_pkg::AXI_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  assign start_cmd   = wr_fire && awaddr_q == ebrp_pkg::HOST_CTRL_OFS && wstrb_q[0]
                       && wdata_q[ebrp_pkg::CTRL_START_BIT];
  assign release_cmd = wr_fire && awaddr_q == ebrp_pkg::HOST_CTRL_OFS && wstrb_q[0]
                       && wdata_q[ebrp_pkg::CTRL_RELEASE_BIT];
  assign copy_cmd    = wr_fire && awaddr_q == ebrp_pkg::HOST_CDATA_OFS;

  ////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_addr_q <= ebrp_pkg::WORD_RST_VAL;
      entry_q      <= ebrp_pkg::WORD_RST_VAL;
      copy_addr_q  <= ebrp_pkg::WORD_RST_VAL;
      copy_data_q  <= ebrp_pkg::WORD_RST_VAL;
      irq_mask_q   <= ebrp_pkg::IRQ_RST_VAL;
    end else if (wr_fire) begin
      case (awaddr_q)
        ebrp_pkg::HOST_RADDR_OFS:  reset_addr_q <= ebrp_pkg::ebrp_strb(reset_addr_q, wdata_q, wstrb_q);
        ebrp_pkg::HOST_ENTRY_OFS:  entry_q <= ebrp_pkg::ebrp_strb(entry_q, wdata_q, wstrb_q);
        ebrp_pkg::HOST_CADDR_OFS:  copy_addr_q <= ebrp_pkg::ebrp_strb(copy_addr_q, wdata_q, wstrb_q);
        ebrp_pkg::HOST_CDATA_OFS:  copy_data_q <= ebrp_pkg::ebrp_strb(copy_data_q, wdata_q, wstrb_q);
        ebrp_pkg::HOST_IRQMSK_OFS: irq_mask_q <= wstrb_q[0] ? wdata_q[2:0] : irq_mask_q;
        default: irq_mask_q <= irq_mask_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // boot sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q     <= ST_IDLE;
      mem_addr_q  <= ebrp_pkg::WORD_RST_VAL;
      mem_wdata_q <= ebrp_pkg::WORD_RST_VAL;
      done_q      <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_cmd) begin
            done_q  <= 1'b0;
            state_q <= ST_CLEAR;
          end
        end
        ST_CLEAR: state_q <= ST_REQ;
        ST_REQ:   state_q <= ST_POLL;
        ST_POLL:  state_q <= ST_WAIT;
        ST_WAIT: begin
          if (bus.rvalid) begin
            state_q <= bus.rdata[0] ? ST_LOADED : ST_POLL;
          end
        end
        ST_LOADED: begin
          if (copy_cmd) begin
            mem_addr_q  <= copy_addr_q;
            mem_wdata_q <= ebrp_pkg::ebrp_strb(copy_data_q, wdata_q, wstrb_q);
            state_q     <= ST_COPY;
          end else if (release_cmd && disp_ok) begin
            mem_addr_q  <= reset_addr_q;
            mem_wdata_q <= ebrp_pkg::ebrp_branch(disp);
            state_q     <= ST_BRANCH;
          end
        end
        ST_COPY: begin
          if (mem_ready) begin
            state_q <= ST_LOADED;
          end
        end
        ST_BRANCH: begin
          if (mem_ready) begin
            state_q <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          done_q  <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port bus strobes decoded from the sequencer state
  always_comb begin
    bus.addr  = ebrp_pkg::PORT_DATA_OFS;
    bus.write = 1'b0;
    bus.read  = 1'b0;
    bus.wdata = ebrp_pkg::WORD_RST_VAL;
    case (state_q)
      ST_CLEAR: begin
        bus.addr  = ebrp_pkg::PORT_EDGE_OFS;
        bus.write = 1'b1;
      end
      ST_REQ: begin
        bus.write = 1'b1;
        bus.wdata = 32'h0000_0001;
      end
      ST_POLL: begin
        bus.addr = ebrp_pkg::PORT_EDGE_OFS;
        bus.read = 1'b1;
      end
      ST_RELEASE: begin
        bus.write = 1'b1;
      end
      default: bus.read = 1'b0;
    endcase
  end

  assign mem_valid = state_q == ST_COPY || state_q == ST_BRANCH;
  assign mem_addr  = mem_addr_q;
  assign mem_wdata = mem_wdata_q;

  ////////////////////////////////////////////////////////////////////////
  // sticky events, write one to clear, set wins
  assign ev[ebrp_pkg::EV_HELD_BIT] = state_q == ST_WAIT && bus.rvalid && bus.rdata[0];
  assign ev[ebrp_pkg::EV_DONE_BIT] = state_q == ST_RELEASE;
  assign ev[ebrp_pkg::EV_ERR_BIT]  = (release_cmd && state_q == ST_LOADED && !copy_cmd && !disp_ok)
                                     || (release_cmd && state_q != ST_LOADED)
                                     || (copy_cmd && state_q != ST_LOADED);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q <= ebrp_pkg::IRQ_RST_VAL;
    end else if (wr_fire && awaddr_q == ebrp_pkg::HOST_IRQST_OFS && wstrb_q[0]) begin
      irq_st_q <= (irq_st_q & ~wdata_q[2:0]) | ev;
    end else begin
      irq_st_q <= irq_st_q | ev;
    end
  end
  assign irq = |(irq_st_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= ebrp_pkg::WORD_RST_VAL;
      rresp_q  <= ebrp_pkg::AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= ebrp_pkg::AXI_OKAY;
      case (s_axi_araddr)
        ebrp_pkg::HOST_CTRL_OFS:   rdata_q <= ebrp_pkg::WORD_RST_VAL;
        ebrp_pkg::HOST_STAT_OFS:   rdata_q <= {24'h00_0000, !disp_ok, done_q, state_q == ST_LOADED,
                                               state_q != ST_IDLE, state_q};
        ebrp_pkg::HOST_RADDR_OFS:  rdata_q <= reset_addr_q;
        ebrp_pkg::HOST_ENTRY_OFS:  rdata_q <= entry_q;
        ebrp_pkg::HOST_CADDR_OFS:  rdata_q <= copy_addr_q;
        ebrp_pkg::HOST_CDATA_OFS:  rdata_q <= copy_data_q;
        ebrp_pkg::HOST_IRQST_OFS:  rdata_q <= {29'h0000_0000, irq_st_q};
        ebrp_pkg::HOST_IRQMSK_OFS: rdata_q <= {29'h0000_0000, irq_mask_q};
        ebrp_pkg::HOST_BRWORD_OFS: rdata_q <= ebrp_pkg::ebrp_branch(disp);
        default: begin
          rdata_q <= ebrp_pkg::WORD_RST_VAL;
          rresp_q <= ebrp_pkg::AXI_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule : ebrp_host

// *** verilog/ebrp_pkg.sv ***
// shared constants and helpers for the external boot reset port and its host
package ebrp_pkg;

  // port register word offsets
  localparam logic [1:0] PORT_DATA_OFS = 2'h0;
  localparam logic [1:0] PORT_EDGE_OFS = 2'h3;
  localparam logic       PORT_RST_VAL  = 1'b0;

  // relative branch word layout
  localparam logic [5:0] BR_OPCODE     = 6'h06;
  localparam int         BR_DISP_LSB   = 6;
  localparam logic [31:0] BR_PC_ADJUST = 32'h0000_0004;

  // host register byte offsets
  localparam logic [7:0] HOST_CTRL_OFS   = 8'h00;
  localparam logic [7:0] HOST_STAT_OFS   = 8'h04;
  localparam logic [7:0] HOST_RADDR_OFS  = 8'h08;
  localparam logic [7:0] HOST_ENTRY_OFS  = 8'h0C;
  localparam logic [7:0] HOST_CADDR_OFS  = 8'h10;
  localparam logic [7:0] HOST_CDATA_OFS  = 8'h14;
  localparam logic [7:0] HOST_IRQST_OFS  = 8'h18;
  localparam logic [7:0] HOST_IRQMSK_OFS = 8'h1C;
  localparam logic [7:0] HOST_BRWORD_OFS = 8'h20;

  // control and event bit positions
  localparam int CTRL_START_BIT   = 0;
  localparam int CTRL_RELEASE_BIT = 1;
  localparam int EV_HELD_BIT      = 0;
  localparam int EV_DONE_BIT      = 1;
  localparam int EV_ERR_BIT       = 2;
  localparam logic [2:0] IRQ_RST_VAL  = 3'h0;
  localparam logic [31:0] WORD_RST_VAL = 32'h0000_0000;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // displacement: entry minus reset address minus one instruction
  function automatic logic [31:0] ebrp_disp(input logic [31:0] reset_addr, input logic [31:0] entry);
    ebrp_disp = entry - reset_addr - BR_PC_ADJUST;
  endfunction : ebrp_disp

  // aligned and within the signed 16-bit field
  function automatic logic ebrp_disp_ok(input logic [31:0] disp);
    ebrp_disp_ok = (disp[1:0] == 2'b00) && ((disp[31:15] == 17'h0_0000) || (disp[31:15] == 17'h1_FFFF));
  endfunction : ebrp_disp_ok

  function automatic logic [31:0] ebrp_branch(input logic [31:0] disp);
    ebrp_branch = {10'h000, disp[15:0], BR_OPCODE};
  endfunction : ebrp_branch

  function automatic logic [31:0] ebrp_strb(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] s);
    ebrp_strb = {s[3] ? wd[31:24] : old[31:24], s[2] ? wd[23:16] : old[23:16],
                 s[1] ? wd[15:8] : old[15:8], s[0] ? wd[7:0] : old[7:0]};
  endfunction : ebrp_strb

endpackage : ebrp_pkg

// *** verilog/ebrp_port.sv ***
// one-bit reset request port with rising-edge capture of the acknowledge pulse
`timescale 1ns/1ps
module ebrp_port (
  input  wire logic aclk,
  input  wire logic aresetn,
  ebrp_bus_if.port_end bus,
  output wire logic core_reset_req,
  input  wire logic core_reset_ack
);

  logic req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_s3_q;
  logic edge_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic rise;

  ////////////////////////////////////////////////////////////////////////
  // output bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q <= ebrp_pkg::PORT_RST_VAL;
    end else if (bus.write && bus.addr == ebrp_pkg::PORT_DATA_OFS) begin
      req_q <= bus.wdata[0];
    end
  end
  assign core_reset_req = req_q;

  ////////////////////////////////////////////////////////////////////////
  // acknowledge synchroniser and rising-edge detect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
    end else begin
      ack_s1_q <= core_reset_ack;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
    end
  end
  assign rise = ack_s2_q && !ack_s3_q;

  ////////////////////////////////////////////////////////////////////////
  // edge capture: set wins over the clearing write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_q <= ebrp_pkg::PORT_RST_VAL;
    end else if (rise) begin
      edge_q <= 1'b1;
    end else if (bus.write && bus.addr == ebrp_pkg::PORT_EDGE_OFS) begin
      edge_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path, one cycle latency; unused offsets read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q  <= ebrp_pkg::WORD_RST_VAL;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= bus.read;
      if (bus.read) begin
        case (bus.addr)
          ebrp_pkg::PORT_DATA_OFS: rdata_q <= {31'h0000_0000, ack_s2_q};
          ebrp_pkg::PORT_EDGE_OFS: rdata_q <= {31'h0000_0000, edge_q};
          default: rdata_q <= ebrp_pkg::WORD_RST_VAL;
        endcase
      end
    end
  end
  assign bus.rdata  = rdata_q;
  assign bus.rvalid = rvalid_q;

endmodule : ebrp_port
